// file: hw/iam_pkg.sv
package iam_pkg;

  // ==========================================================
  // Address space and register map
  localparam int        ADDR_W         = 24;
  localparam logic [7:0] OFS_ECH       = 8'h80;
  localparam logic [7:0] OFS_ECL       = 8'h81;
  localparam logic [7:0] OFS_CCRH      = 8'h82;
  localparam logic [7:0] OFS_CCRL      = 8'h83;
  localparam logic [7:0] OFS_PCH       = 8'h85;
  localparam logic [7:0] OFS_PCM       = 8'h86;
  localparam logic [7:0] OFS_PCL       = 8'h87;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h90;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h91;
  localparam logic [7:0] OFS_DBG_STAT  = 8'h92;
  localparam logic [7:0] OFS_CTRL      = 8'h93;
  localparam logic [15:0] EC_CLEAR_KEY = 16'hffff;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;

  // ==========================================================
  // Error code field encodings
  localparam logic [3:0] INIT_NONE  = 4'h0;
  localparam logic [3:0] INIT_CPU   = 4'h1;
  localparam logic [3:0] INIT_ADC   = 4'h3;
  localparam logic [3:0] TARGET_NONE = 4'h0;
  localparam logic [3:0] TARGET_REG  = 4'h1;
  localparam logic [3:0] TARGET_RAM  = 4'h2;
  localparam logic [3:0] TARGET_EEP  = 4'h3;
  localparam logic [3:0] TARGET_PFL  = 4'h4;
  localparam logic [3:0] TARGET_IFR  = 4'h5;
  localparam logic [3:0] KIND_OPF   = 4'h1;
  localparam logic [3:0] KIND_VEC   = 4'h2;
  localparam logic [3:0] KIND_LD    = 4'h3;
  localparam logic [3:0] KIND_ST    = 4'h4;
  localparam logic [3:0] ERR_ILL  = 4'h1;
  localparam logic [3:0] ERR_ECC  = 4'h2;

  // ==========================================================
  // Status bit positions (sticky and debug flags)
  localparam int ST_CPU_EXC = 0;
  localparam int ST_ADC_ERR = 1;
  localparam int ST_DBG_ILL = 2;
  localparam int ST_DBG_ECC = 3;
  localparam int DBG_ILL    = 0;
  localparam int DBG_WRFAULT = 1;
  localparam int DBG_RDBAD   = 2;

  // Region classes from the address decoder
  typedef enum logic [2:0] {
    RG_REG   = 3'h0,
    RG_RAM   = 3'h1,
    RG_EEP   = 3'h2,
    RG_RSV   = 3'h3,
    RG_RSVRO = 3'h4,
    RG_IFR   = 3'h5,
    RG_PFL   = 3'h6,
    RG_UNMAP = 3'h7
  } iam_region_e;

  typedef enum logic [1:0] {
    IN_CPU = 2'h0,
    IN_DBG = 2'h1,
    IN_ADC = 2'h2
  } iam_init_e;

  // One observed bus access
  typedef struct packed {
    logic             valid;
    iam_init_e        init;
    logic [ADDR_W-1:0] addr;
    logic             write;
    logic             fetch;
    logic             vector;
    logic             eccErr;
    logic             nvmBusy;
    logic             nvmSupported;
  } iam_access_s;

  // Captured error code
  typedef struct packed {
    logic [3:0] initiator;
    logic [3:0] target;
    logic [3:0] kind;
    logic [3:0] err;
  } iam_ecode_s;

endpackage

// file: hw/iam_monitor.sv
`timescale 1ns/10ps
// Summary of operation
// - On a processor fault capture the 24-bit PC of the faulting instruction.
// - After the error code is cleared the captured PC is not meaningful.
// - One 16MB global address space shared by processor, converter, debugger.
// - Every access is classified by initiator, region and kind.
// - Register space: processor/debugger read-write legal; converter or fetch illegal.
// - Reserved space: processor write only in special mode; converter, fetch illegal.
// - RAM all legal; NVM and read-only writes illegal; unmapped illegal.
// - Fetch legal from EEPROM/flash, illegal from IFR; NVM collisions illegal.
// - Processor illegal access raises a machine exception.
// - Debugger illegal access sets the debug illegal-access flag.
// - Converter illegal access raises the converter error interrupt.
// - Prefetch illegal accesses still raise machine exceptions.
// - Uncorrectable ECC on processor or converter access raises a machine exception.
// - Uncorrectable ECC on debugger access sets write-fault or read-invalid flag.
// - A non-zero error code freezes the error code, PC and condition codes.
// - Writing 0xffff across both error code bytes clears them.
// - Initiator and target fields use the documented encodings.
// - Access and error type fields use the documented encodings.
module iam_monitor #(
  parameter logic [23:0] RAM_BASE   = 24'h001000,
  parameter logic [23:0] RAM_TOP    = 24'h001fff,
  parameter logic [23:0] EEP_BASE   = 24'h100000,
  parameter logic [23:0] EEP_TOP    = 24'h1003ff,
  parameter logic [23:0] RSV_TOP    = 24'h0fffff,
  parameter logic [23:0] RO_BASE    = 24'h1f4000,
  parameter logic [23:0] RO_TOP     = 24'h1fbfff,
  parameter logic [23:0] IFR_BASE   = 24'h1fc000,
  parameter logic [23:0] IFR_TOP    = 24'h1fffff,
  parameter logic [23:0] PFL_BASE   = 24'hfe0000,
  parameter logic [23:0] REG_TOP    = 24'h000fff
) (
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  sys_rst,
  // Observed access and processor context
  input  wire iam_pkg::iam_access_s  busAccess,
  input  wire logic [23:0]           fault_pc_value,
  input  wire logic [15:0]           cpuCcr,
  input  wire logic                  specialMode,
  // Avalon-MM slave
  input  wire logic [7:0]            avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  input  wire logic [3:0]            avs_byteenable,
  output logic [31:0]                avs_readdata,
  output logic                       avs_waitrequest,
  output logic [1:0]                 avs_response,
  // Fault reporting
  output logic                       machineException,
  output logic                       adcErrorIrq,
  output logic [2:0]                 debugStatus,
  output logic                       irq
);

  // Region bounds must be ordered and must not overlap
  if (RAM_BASE > RAM_TOP || RAM_BASE <= REG_TOP || EEP_BASE > EEP_TOP
      || RO_BASE > RO_TOP || IFR_BASE > IFR_TOP || PFL_BASE <= IFR_TOP) begin : g_badBounds
    $error("iam_monitor: bad region bounds");
  end

  // ==========================================================
  // Region decode
  // 24-bit global map
  function automatic iam_pkg::iam_region_e regionOf(input logic [23:0] a);
    if (a <= REG_TOP) regionOf = iam_pkg::RG_REG;
    else if (a >= RAM_BASE && a <= RAM_TOP) regionOf = iam_pkg::RG_RAM;
    else if (a >= EEP_BASE && a <= EEP_TOP) regionOf = iam_pkg::RG_EEP;
    else if (a <= RSV_TOP) regionOf = iam_pkg::RG_RSV;
    else if (a >= RO_BASE && a <= RO_TOP) regionOf = iam_pkg::RG_RSVRO;
    else if (a >= IFR_BASE && a <= IFR_TOP) regionOf = iam_pkg::RG_IFR;
    else if (a >= PFL_BASE) regionOf = iam_pkg::RG_PFL;
    else regionOf = iam_pkg::RG_UNMAP;
  endfunction

  wire iam_pkg::iam_region_e region = regionOf(busAccess.addr);
  wire isAdc   = busAccess.init == iam_pkg::IN_ADC;
  wire isDbg   = busAccess.init == iam_pkg::IN_DBG;
  wire isCpu   = busAccess.init == iam_pkg::IN_CPU;
  wire isWr    = busAccess.write;
  wire isFetch = busAccess.fetch;
  wire isNvm   = region == iam_pkg::RG_EEP || region == iam_pkg::RG_PFL
                 || region == iam_pkg::RG_IFR;

  // ==========================================================
  // Legality table
  logic illegal;
  always_comb begin
    case (region)
      iam_pkg::RG_REG:   illegal = isAdc || isFetch;
      iam_pkg::RG_RAM:   illegal = 1'b0;
      iam_pkg::RG_EEP,
      iam_pkg::RG_PFL:   illegal = isWr;
      iam_pkg::RG_RSV:   illegal = isAdc || isFetch || (isCpu && isWr && !specialMode);
      iam_pkg::RG_RSVRO,
      iam_pkg::RG_IFR:   illegal = isWr || isFetch || isAdc;
      default:           illegal = 1'b1;
    endcase
    if (isNvm && busAccess.nvmBusy && !busAccess.nvmSupported) begin
      illegal = 1'b1;
    end
  end

  wire illEvt = busAccess.valid && illegal;
  wire eccEvt = busAccess.valid && !illegal && busAccess.eccErr;

  // ==========================================================
  // Error code composition
  wire logic [3:0] targetCode =
      (region == iam_pkg::RG_REG) ? iam_pkg::TARGET_REG :
      (region == iam_pkg::RG_RAM) ? iam_pkg::TARGET_RAM :
      (region == iam_pkg::RG_EEP) ? iam_pkg::TARGET_EEP :
      (region == iam_pkg::RG_PFL) ? iam_pkg::TARGET_PFL :
      (region == iam_pkg::RG_IFR) ? iam_pkg::TARGET_IFR : iam_pkg::TARGET_NONE;
  wire logic [3:0] kindCode =
      busAccess.vector ? iam_pkg::KIND_VEC :
      isFetch ? iam_pkg::KIND_OPF :
      isWr ? iam_pkg::KIND_ST : iam_pkg::KIND_LD;
  wire iam_pkg::iam_ecode_s newCode = '{
      initiator: isAdc ? iam_pkg::INIT_ADC : iam_pkg::INIT_CPU,
      target: targetCode,
      kind: kindCode,
      err: illEvt ? iam_pkg::ERR_ILL : iam_pkg::ERR_ECC};

  // Fault event classes
  // machine exception sources
  wire cpuExcEvt = isCpu && (illEvt || eccEvt) || isAdc && eccEvt;
  wire adcIllEvt = isAdc && illEvt;
  wire dbgIllEvt = isDbg && illEvt;
  wire dbgEccEvt = isDbg && eccEvt;
  wire captEvt   = (isCpu || isAdc) && (illEvt || eccEvt);

  // ==========================================================
  // Bus decode
  wire rdAcc = avs_read && avs_waitrequest;
  wire wrAcc = avs_write && avs_waitrequest;
  wire hitEc = avs_address == iam_pkg::OFS_ECH;
  wire hitSt = avs_address == iam_pkg::OFS_IRQ_STAT;
  wire hitMk = avs_address == iam_pkg::OFS_IRQ_MASK;
  wire hitDs = avs_address == iam_pkg::OFS_DBG_STAT;
  wire ecClear = wrAcc && hitEc && avs_byteenable[1:0] == 2'h3
                 && avs_writedata[15:0] == iam_pkg::EC_CLEAR_KEY;
  wire stRead  = rdAcc && hitSt;
  wire dsWrite = wrAcc && hitDs;

  // ==========================================================
  // State
  iam_pkg::iam_ecode_s ecode_ff;
  logic [23:0]         pc_ff;
  logic [15:0]         ccr_ff;
  logic [3:0]          stat_ff;
  logic [3:0]          mask_ff;
  logic [2:0]          dbg_ff;
  logic [31:0]         rdata_ff;
  logic                wait_ff;
  logic [1:0]          resp_ff;
  logic                exc_ff;
  logic                adcIrq_ff;
  logic                irq_ff;

  wire ecZero = ecode_ff == '0;
  wire doCapt = captEvt && ecZero;

  wire logic [3:0] evtVec = {dbgEccEvt, dbgIllEvt, adcIllEvt, cpuExcEvt};
  // Set wins over read-clear
  wire logic [3:0] nxt_stat = (stRead ? 4'h0 : stat_ff) | evtVec;
  // debug flags, write one to clear
  wire logic [2:0] dbgSet = {dbgEccEvt && !isWr, dbgEccEvt && isWr, dbgIllEvt};
  wire logic [2:0] nxt_dbg = (dsWrite ? dbg_ff & ~avs_writedata[2:0] : dbg_ff) | dbgSet;

  // Read mux
  logic [31:0] nxt_rdata;
  logic        unmapped;
  always_comb begin
    nxt_rdata = 32'h0;
    unmapped  = 1'b0;
    case (avs_address)
      iam_pkg::OFS_ECH:      nxt_rdata = {16'h0, ecode_ff};
      iam_pkg::OFS_CCRH:     nxt_rdata = {16'h0, ccr_ff};
      iam_pkg::OFS_PCH:      nxt_rdata = {8'h0, pc_ff};
      iam_pkg::OFS_IRQ_STAT: nxt_rdata = {28'h0, stat_ff};
      iam_pkg::OFS_IRQ_MASK: nxt_rdata = {28'h0, mask_ff};
      iam_pkg::OFS_DBG_STAT: nxt_rdata = {29'h0, dbg_ff};
      default:               unmapped  = 1'b1;
    endcase
  end

  // Bus handshake: one wait cycle then ack
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wait_ff  <= 1'b1;
      rdata_ff <= 32'h0;
      resp_ff  <= iam_pkg::RESP_OKAY;
    end else begin
      wait_ff  <= !(rdAcc || wrAcc);
      rdata_ff <= rdAcc ? nxt_rdata : rdata_ff;
      resp_ff  <= (rdAcc || wrAcc)
                  ? (unmapped ? iam_pkg::RESP_SLVERR : iam_pkg::RESP_OKAY) : resp_ff;
    end
  end

  // Capture registers
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ecode_ff <= '0;
      pc_ff    <= 24'h0;
      ccr_ff   <= 16'h0;
    end else if (doCapt) begin
      ecode_ff <= newCode;
      pc_ff    <= fault_pc_value;
      ccr_ff   <= cpuCcr;
    end else if (ecClear) begin
      ecode_ff <= '0;
    end
  end

  // Status, mask and outputs
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      stat_ff   <= 4'h0;
      mask_ff   <= 4'h0;
      dbg_ff    <= 3'h0;
      exc_ff    <= 1'b0;
      adcIrq_ff <= 1'b0;
      irq_ff    <= 1'b0;
    end else begin
      stat_ff   <= nxt_stat;
      mask_ff   <= (wrAcc && hitMk) ? avs_writedata[3:0] : mask_ff;
      dbg_ff    <= nxt_dbg;
      exc_ff    <= cpuExcEvt;
      adcIrq_ff <= adcIllEvt;
      irq_ff    <= |(nxt_stat & ((wrAcc && hitMk) ? avs_writedata[3:0] : mask_ff));
    end
  end

  assign avs_readdata     = rdata_ff;
  assign avs_waitrequest  = wait_ff;
  assign avs_response     = resp_ff;
  assign machineException = exc_ff;
  assign adcErrorIrq      = adcIrq_ff;
  assign debugStatus      = dbg_ff;
  assign irq              = irq_ff;

  // ==========================================================
  // Assertions
  property p_exc;
    @(posedge ref_clk) disable iff (sys_rst)
      (busAccess.valid && isCpu && illegal) |=> machineException;
  endproperty
  a_exc: assert property (p_exc) else $error("cpu illegal without exception");

  property p_adc;
    @(posedge ref_clk) disable iff (sys_rst)
      (busAccess.valid && isAdc && illegal) |=> adcErrorIrq && !machineException;
  endproperty
  a_adc: assert property (p_adc) else $error("adc illegal without interrupt");

  property p_dbg;
    @(posedge ref_clk) disable iff (sys_rst)
      (busAccess.valid && isDbg && illegal) |=> debugStatus[iam_pkg::DBG_ILL];
  endproperty
  a_dbg: assert property (p_dbg) else $error("debug illegal flag not set");

  property p_dbgnoexc;
    @(posedge ref_clk) disable iff (sys_rst)
      (busAccess.valid && isDbg) |=> !machineException;
  endproperty
  a_dbgnoexc: assert property (p_dbgnoexc) else $error("debug access raised exception");

  property p_ram;
    @(posedge ref_clk) disable iff (sys_rst)
      (busAccess.valid && region == iam_pkg::RG_RAM && !busAccess.eccErr)
        |=> !machineException && !adcErrorIrq;
  endproperty
  a_ram: assert property (p_ram) else $error("ram access flagged illegal");

  property p_hold;
    @(posedge ref_clk) disable iff (sys_rst)
      (!ecZero && !ecClear) |=> $stable(pc_ff) && $stable(ecode_ff) && $stable(ccr_ff);
  endproperty
  a_hold: assert property (p_hold) else $error("capture changed while held");

  property p_clr;
    @(posedge ref_clk) disable iff (sys_rst)
      (ecClear && !doCapt) |=> ecZero;
  endproperty
  a_clr: assert property (p_clr) else $error("error code not cleared");

  property p_pc;
    @(posedge ref_clk) disable iff (sys_rst)
      doCapt |=> pc_ff == $past(fault_pc_value) && ecode_ff.initiator != iam_pkg::INIT_NONE;
  endproperty
  a_pc: assert property (p_pc) else $error("pc not captured");

endmodule

// file: verif/iam_initiator_model.sv
`timescale 1ns/10ps
// ====================
// Bus initiator stand-in
module iam_initiator_model (
  // Clock
  input  wire logic            ref_clk,
  // Access and processor context
  output iam_pkg::iam_access_s busAccess,
  output logic [23:0]          fault_pc_value,
  output logic [15:0]          cpuCcr
);
  // Quiet bus at start
  initial begin
    busAccess = '0;
    fault_pc_value = 24'h000000;
    cpuCcr = 16'h0000;
  end
  // One access for one cycle, then released
  task automatic issue(input iam_pkg::iam_access_s a, input logic [23:0] pc);
    @(posedge ref_clk);
    busAccess <= a;
    fault_pc_value <= pc;
    cpuCcr <= ~pc[15:0];
    @(posedge ref_clk);
    busAccess.valid <= 1'b0;
    busAccess.addr <= ~a.addr; // Stale address scrambled
    fault_pc_value <= ~pc;
  endtask
endmodule

// file: verif/tb_top.sv
`timescale 1ns/10ps
// ====================
// Monitor testbench
module tb_top;
  logic                 ref_clk, sys_rst, specialMode;
  iam_pkg::iam_access_s busAccess;
  logic [23:0]          fault_pc_value;
  logic [15:0]          cpuCcr;
  logic [7:0]           avsAddr;
  logic [3:0]           avsBe;
  logic                 avsRead, avsWrite, avsWait, mExc, adcIrq, irq;
  logic [31:0]          avsWdata, avsRdata, d;
  logic [1:0]           avsResp, lastResp;
  logic [2:0]           dbgStat;
  int                   numErrors, checkCount;
  logic [23:0] addrTab [8] = '{24'h000100, 24'h001100, 24'h100100, 24'h002000,
                               24'h1f5000, 24'h1fd000, 24'hfe1000, 24'h300000};
  logic [3:0]  targetTab [8] = '{4'h1, 4'h2, 4'h3, 4'h0, 4'h0, 4'h5, 4'h4, 4'h0};
  logic [3:0]  kindTab [4] = '{4'h3, 4'h4, 4'h1, 4'h2};

  iam_initiator_model iam_initiator_model_i (.ref_clk(ref_clk), .busAccess(busAccess),
    .fault_pc_value(fault_pc_value), .cpuCcr(cpuCcr));
  iam_monitor iam_monitor_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .busAccess(busAccess),
    .fault_pc_value(fault_pc_value), .cpuCcr(cpuCcr), .specialMode(specialMode), .avs_address(avsAddr),
    .avs_read(avsRead), .avs_write(avsWrite), .avs_writedata(avsWdata),
    .avs_byteenable(avsBe), .avs_readdata(avsRdata), .avs_waitrequest(avsWait),
    .avs_response(avsResp), .machineException(mExc), .adcErrorIrq(adcIrq),
    .debugStatus(dbgStat), .irq(irq));

  // Clock
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge ref_clk);
    numErrors++;
    report_and_stop();
  end

  // Legality per initiator, region and kind
  function automatic logic legal(input int ini, input int rg, input int kind, input logic sm);
    if (kind == 2) return rg == 1 || rg == 2 || rg == 6;
    case (rg)
      0: return ini != 2;
      1: return 1'b1;
      2, 6: return kind == 0;
      3: return ini != 2 && (kind == 0 || ini == 1 || sm);
      4, 5: return kind == 0 && ini != 2;
      default: return 1'b0;
    endcase
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      numErrors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Avalon read, held until waitrequest low
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] q);
    @(posedge ref_clk);
    avsRead <= 1'b1;
    avsAddr <= a;
    do @(posedge ref_clk); while (avsWait !== 1'b0);
    q = avsRdata;
    lastResp = avsResp;
    avsRead <= 1'b0;
  endtask
  // Avalon write, held until waitrequest low
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    avsWrite <= 1'b1;
    avsAddr <= a;
    avsWdata <= v;
    do @(posedge ref_clk); while (avsWait !== 1'b0);
    avsWrite <= 1'b0;
  endtask
  // Rearm capture, clear flags
  task automatic clr();
    logic [31:0] q;
    bus_wr(iam_pkg::OFS_ECH, 32'h0000ffff);
    bus_wr(iam_pkg::OFS_DBG_STAT, 32'h00000007);
    bus_rd(iam_pkg::OFS_IRQ_STAT, q);
  endtask
  task automatic go(input int ini, input int rg, input int kind, input logic ecc,
                    input logic busy, input logic [23:0] pc);
    iam_pkg::iam_access_s a;
    a = '{valid: 1'b1, init: iam_pkg::iam_init_e'(ini), addr: addrTab[rg],
          write: kind == 1, fetch: kind == 2, vector: kind == 3, eccErr: ecc,
          nvmBusy: busy, nvmSupported: ~busy};
    iam_initiator_model_i.issue(a, pc);
    @(negedge ref_clk);
  endtask
  task automatic run_case(input int ini, input int rg, input int kind);
    logic        ill;
    logic [15:0] m, e;
    logic [23:0] pc;
    logic [31:0] q;
    ill = !legal(ini, rg, kind, specialMode);
    pc = {8'h3c, 8'(rg), 8'(kind)};
    m = (targetTab[rg] == 4'h0) ? 16'hf0ff : 16'hffff;
    e = (ill && ini != 1) ? {(ini == 0) ? 4'h1 : 4'h3, targetTab[rg], kindTab[kind], 4'h1}
                          : 16'h0;
    go(ini, rg, kind, 1'b0, 1'b0, pc);
    check(mExc, ini == 0 && ill);
    check(adcIrq, ini == 2 && ill);
    check(dbgStat[0], ini == 1 && ill);
    check(irq, 1'b0);
    bus_rd(iam_pkg::OFS_ECH, q);
    check(q[15:0] & m, e & m);
    if (ill && ini == 0) begin
      bus_rd(iam_pkg::OFS_PCH, q);
      check(q, {8'h00, pc});
    end
    clr();
  endtask
  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", checkCount, numErrors);
    if (numErrors == 0 && checkCount > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    sys_rst = 1'b1;
    specialMode = 1'b0;
    {avsAddr, avsRead, avsWrite, avsWdata} = '0;
    avsBe = 4'hf;
    numErrors = 0;
    checkCount = 0;
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'b0;
    for (int sm = 0; sm < 2; sm++) begin
      specialMode <= sm[0];
      for (int i = 0; i < 3; i++)
        for (int r = 0; r < 8; r++)
          for (int k = 0; k < 3; k++)
            if (k < 2 || i == 0) run_case(i, r, k);
    end
    // Vector fetch and NVM collision
    go(0, 7, 3, 1'b0, 1'b0, 24'h000010);
    check(mExc, 1'b1);
    bus_rd(iam_pkg::OFS_ECH, d);
    check(d[15:0] & 16'hf0ff, 16'h1021);
    clr();
    go(0, 2, 0, 1'b0, 1'b1, 24'h000020);
    check(mExc, 1'b1);
    bus_rd(iam_pkg::OFS_ECH, d);
    check(d[15:0], 16'h1331);
    clr();
    // Uncorrectable ECC per initiator
    go(0, 1, 0, 1'b1, 1'b0, 24'h000030);
    check(mExc, 1'b1);
    bus_rd(iam_pkg::OFS_ECH, d);
    check(d[15:0], 16'h1232);
    clr();
    go(2, 6, 0, 1'b1, 1'b0, 24'h000040);
    check({mExc, adcIrq}, 2'b10);
    bus_rd(iam_pkg::OFS_ECH, d);
    check(d[15:0], 16'h3432);
    clr();
    go(1, 1, 1, 1'b1, 1'b0, 24'h000050);
    check({mExc, dbgStat}, 4'b0010);
    clr();
    go(1, 1, 0, 1'b1, 1'b0, 24'h000060);
    check({mExc, dbgStat}, 4'b0100);
    clr();
    // First fault kept, clear key exact
    go(0, 0, 2, 1'b0, 1'b0, 24'h123456);
    go(2, 0, 0, 1'b0, 1'b0, 24'h654321);
    check(adcIrq, 1'b1);
    bus_rd(iam_pkg::OFS_ECH, d);
    check(d[15:0], 16'h1111);
    bus_rd(iam_pkg::OFS_PCH, d);
    check(d, 32'h00123456);
    bus_rd(iam_pkg::OFS_CCRH, d);
    check(d[15:0], 16'hcba9);
    bus_wr(iam_pkg::OFS_ECH, 32'h0000fffe);
    bus_rd(iam_pkg::OFS_ECH, d);
    check(d[15:0], 16'h1111);
    // Key in the low byte only must not clear
    avsBe <= 4'h1;
    bus_wr(iam_pkg::OFS_ECH, 32'h0000ffff);
    avsBe <= 4'hf;
    bus_rd(iam_pkg::OFS_ECH, d);
    check(d[15:0], 16'h1111);
    bus_wr(iam_pkg::OFS_ECH, 32'h0000ffff);
    bus_rd(iam_pkg::OFS_ECH, d);
    check(d[15:0], 16'h0000);
    clr();
    // Interrupt unmasked, read-cleared, then masked
    bus_wr(iam_pkg::OFS_IRQ_MASK, 32'h00000001);
    go(0, 7, 0, 1'b0, 1'b0, 24'h000070);
    @(negedge ref_clk);
    check(irq, 1'b1);
    bus_rd(iam_pkg::OFS_IRQ_STAT, d);
    check(d, 32'h00000001);
    repeat (2) @(negedge ref_clk);
    check(irq, 1'b0);
    bus_rd(iam_pkg::OFS_IRQ_MASK, d);
    check(d, 32'h00000001);
    clr();
    bus_wr(iam_pkg::OFS_IRQ_MASK, 32'h00000000);
    go(0, 7, 0, 1'b0, 1'b0, 24'h000080);
    repeat (2) @(negedge ref_clk);
    check(irq, 1'b0);
    clr();
    // Unmapped register index refused
    bus_rd(8'h40, d);
    check({lastResp, d}, {2'h2, 32'h0});
    report_and_stop();
  end
endmodule
